// [include/fhri_pkg.sv]
// Package with offsets, fields, reset values and timing of the register file.
package fhri_pkg;
	// Byte offsets from the controller base.
	localparam logic [2:0] OFS_DRIVE_CTRL = 3'h2;
	localparam logic [2:0] OFS_RATE_STAT = 3'h4;
	localparam logic [2:0] OFS_BYTE_PORT = 3'h5;
	localparam logic [2:0] OFS_ALT_RATE = 3'h7;
	// Drive control fields.
	localparam int DC_MOTOR_LO = 4;
	localparam int DC_DMA_EN = 3;
	localparam int DC_RUN = 2;
	localparam logic [7:0] DC_WMASK = 8'h3f;
	localparam logic [7:0] DC_RESET = 8'h00;
	// Rate select fields.
	localparam int RS_SRESET = 7;
	localparam int RS_LOWPWR = 6;
	localparam int RS_PCOMP_LO = 2;
	localparam logic [2:0] PCOMP_RESET = 3'h0;
	localparam logic [1:0] RATE_RESET = 2'h2;
	// Status fields.
	localparam int ST_RQM = 7;
	localparam int ST_DIO = 6;
	localparam int ST_NONDMA = 5;
	localparam int ST_CMDBSY = 4;
	localparam int DCH_BIT = 7;
	// Least software reset time and its cycle count at 200 MHz.
	localparam int RST_MIN_NS = 100;
	localparam int CLK_PERIOD_NS = 5;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [rtl/fhri_drive_decode.sv]
// Drive select decoder turning a drive number into one-hot active-low selects.
`timescale 1ns/1ps
`default_nettype none
module fhri_drive_decode #(
	parameter int DRIVES = 4
) (
	input wire logic [$clog2(DRIVES)-1:0] drive_num,
	output logic [DRIVES-1:0] select_n
);
	// Exactly one select line is low at any time.
	always_comb begin
		select_n = '1;
		select_n[drive_num] = 1'b0;
	end
endmodule
`default_nettype wire

// [rtl/fhri_regs.sv]
// Host register file of the floppy controller with byte port handshake.
//
// Function
// - Decode offsets 2, 4, 5, 7; others reserved.
// - Drive control zero on reset, kept on soft reset.
// - Bits 5:4 drive active-low motor outputs.
// - Bit 3 gates DMA and interrupt pins.
// - Bit 2 low holds controller in reset.
// - Bits 1:0 select exactly one drive.
// - Latest rate write from either register wins.
// - Rate select write-only; rate and precomp kept on soft reset.
// - Rate bit 7 resets, then self-clears.
// - Rate bit 6 low power until status read, byte port access or reset.
// - Bits 4:2 select write precompensation amount.
// - Status bit 7 says byte port ready.
// - Status bit 6 gives transfer direction.
// - Status bit 5 shows non-DMA execution.
// - Status bit 4 marks command in progress.
// - Status bits 3:0 show drives seeking.
// - Byte port carries commands, data, results.
// - Alternate rate holds bits 1:0, reset 10b.
// - Status and disk change are read-only.
// - Disk change bit 7 inverts input pin.
`timescale 1ns/1ps
`default_nettype none
module fhri_regs #(
	parameter int DRIVES = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [2:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_oe,
	input wire logic eng_rqm,
	input wire logic eng_dio,
	input wire logic eng_nondma,
	input wire logic eng_cmd_busy,
	input wire logic [3:0] eng_seek_busy,
	output logic [7:0] eng_wdata,
	output logic eng_wstb,
	input wire logic [7:0] eng_rdata,
	output logic eng_rstb,
	output logic eng_reset,
	output logic eng_lowpower,
	output logic [1:0] eng_rate,
	output logic [2:0] eng_precomp,
	output logic [1:0] motor_out_n,
	output logic [DRIVES-1:0] drive_sel_n,
	input wire logic media_change_in_n,
	input wire logic dma_ack_n,
	input wire logic term_count,
	input wire logic eng_drq,
	input wire logic eng_irq,
	output logic dma_ack_n_gated,
	output logic term_count_gated,
	output logic drq_out,
	output logic drq_oe,
	output logic irq_out,
	output logic irq_oe
);
	// Refuse any drive count other than the four that the two-bit select field serves.
	if (DRIVES != 4) begin : g_drives_check
		$error("fhri_regs serves four drives only");
	end

	// --------------------------------------------------------------
	// Register state
	// --------------------------------------------------------------
	logic [7:0] dc_q, dc_d; // Drive control contents.
	logic [2:0] pcomp_q, pcomp_d; // Precompensation select.
	logic [1:0] rate_q, rate_d; // Effective data rate code.
	logic lowpwr_q, lowpwr_d; // Manual low power mode.
	logic [4:0] srst_cnt_q, srst_cnt_d; // Self-clearing reset pulse timer.
	logic [7:0] rdata_q, rdata_d; // Read data latch.
	logic rdoe_q, rdoe_d; // Read data drive enable.
	logic [7:0] wdata_q, wdata_d; // Byte port write data.
	logic wstb_q, wstb_d; // Byte port write strobe.
	logic rstb_q, rstb_d; // Byte port read strobe.
	logic rst_q, rst_d; // Engine reset output.
	logic [1:0] mot_q, mot_d; // Motor outputs.
	logic [DRIVES-1:0] sel_q; // Drive selects.
	logic [DRIVES-1:0] sel_dec; // Decoded selects.
	logic ack_q, tc_q, drq_q, drqoe_q, irq_q, irqoe_q; // Gated pins.
	logic ack_d, tc_d, drqoe_d, irqoe_d; // Gated pin next values.
	logic wr_dc, wr_rs, wr_bp, wr_ar, rd_st, rd_bp, rd_dch; // Decodes.
	logic soft_rst; // Soft reset request this cycle.

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	// Only documented offsets produce strobes; the rest fall through.
	always_comb begin
		wr_dc = host_wr && host_addr == fhri_pkg::OFS_DRIVE_CTRL;
		wr_rs = host_wr && host_addr == fhri_pkg::OFS_RATE_STAT;
		wr_bp = host_wr && host_addr == fhri_pkg::OFS_BYTE_PORT;
		wr_ar = host_wr && host_addr == fhri_pkg::OFS_ALT_RATE;
		rd_st = host_rd && host_addr == fhri_pkg::OFS_RATE_STAT;
		rd_bp = host_rd && host_addr == fhri_pkg::OFS_BYTE_PORT;
		rd_dch = host_rd && host_addr == fhri_pkg::OFS_ALT_RATE;
		soft_rst = wr_rs && host_wdata[fhri_pkg::RS_SRESET];
	end

	// --------------------------------------------------------------
	// Control register next state
	// --------------------------------------------------------------
	// Computes drive control, rate, low power and reset timer updates.
	always_comb begin
		dc_d = dc_q;
		pcomp_d = pcomp_q;
		rate_d = rate_q;
		lowpwr_d = lowpwr_q;
		srst_cnt_d = srst_cnt_q;
		if (wr_dc) begin
			dc_d = host_wdata & fhri_pkg::DC_WMASK;
		end
		if (wr_rs) begin
			// only host writes, soft reset keeps
			pcomp_d = host_wdata[fhri_pkg::RS_PCOMP_LO +: 3];
			rate_d = host_wdata[1:0];
		end else if (wr_ar) begin
			rate_d = host_wdata[1:0];
		end
		if (soft_rst) begin
			srst_cnt_d = 5'(fhri_pkg::RST_MIN_CYC);
		end else if (srst_cnt_q != 5'h00) begin
			srst_cnt_d = srst_cnt_q - 5'h01;
		end
		if (wr_rs && host_wdata[fhri_pkg::RS_LOWPWR] && !soft_rst) begin
			lowpwr_d = 1'b1;
		end else if (rst_d || wr_bp || rd_bp || rd_st) begin
			lowpwr_d = 1'b0;
		end
	end

	// Engine reset, motor and gated pin next values from drive control.
	always_comb begin
		rst_d = !dc_d[fhri_pkg::DC_RUN] || soft_rst || srst_cnt_d != 5'h00;
		mot_d = ~dc_d[fhri_pkg::DC_MOTOR_LO +: 2];
		ack_d = dc_d[fhri_pkg::DC_DMA_EN] ? dma_ack_n : 1'b1;
		tc_d = dc_d[fhri_pkg::DC_DMA_EN] && term_count;
		drqoe_d = dc_d[fhri_pkg::DC_DMA_EN];
		irqoe_d = dc_d[fhri_pkg::DC_DMA_EN];
	end

	// --------------------------------------------------------------
	// Host read and byte port
	// --------------------------------------------------------------
	// Forms read data and byte port strobes.
	always_comb begin
		rdata_d = 8'h00;
		rdoe_d = 1'b0;
		wdata_d = wdata_q;
		wstb_d = 1'b0;
		rstb_d = 1'b0;
		if (rd_st) begin
			rdoe_d = 1'b1;
			rdata_d[fhri_pkg::ST_RQM] = eng_rqm;
			rdata_d[fhri_pkg::ST_DIO] = eng_dio;
			rdata_d[fhri_pkg::ST_NONDMA] = eng_nondma;
			rdata_d[fhri_pkg::ST_CMDBSY] = eng_cmd_busy;
			rdata_d[3:0] = eng_seek_busy;
		end else if (rd_dc_any()) begin
			rdoe_d = 1'b1;
			rdata_d = dc_q;
		end else if (rd_bp) begin
			rdoe_d = 1'b1;
			rdata_d = eng_rdata;
			rstb_d = 1'b1;
		end else if (rd_dch) begin
			rdoe_d = 1'b1;
			rdata_d[fhri_pkg::DCH_BIT] = !media_change_in_n;
		end
		if (wr_bp) begin
			wdata_d = host_wdata;
			wstb_d = 1'b1;
		end
	end

	// Drive control read decode.
	function automatic logic rd_dc_any();
		return host_rd && host_addr == fhri_pkg::OFS_DRIVE_CTRL;
	endfunction

	fhri_drive_decode #(
		.DRIVES(DRIVES)
	) u_dec (
		.drive_num(dc_d[1:0]),
		.select_n(sel_dec)
	);

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	// Registers every next value; hardware reset gives documented defaults.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dc_q <= fhri_pkg::DC_RESET;
			pcomp_q <= fhri_pkg::PCOMP_RESET;
			rate_q <= fhri_pkg::RATE_RESET;
			lowpwr_q <= 1'b0;
			srst_cnt_q <= 5'h00;
			rdata_q <= 8'h00;
			rdoe_q <= 1'b0;
			wdata_q <= 8'h00;
			wstb_q <= 1'b0;
			rstb_q <= 1'b0;
			rst_q <= 1'b1;
			mot_q <= 2'h3;
			// Drive zero stays selected through reset, so one is always chosen.
			sel_q <= ~(DRIVES'(1) << fhri_pkg::DC_RESET[1:0]);
			ack_q <= 1'b1;
			tc_q <= 1'b0;
			drq_q <= 1'b0;
			drqoe_q <= 1'b0;
			irq_q <= 1'b0;
			irqoe_q <= 1'b0;
		end else begin
			dc_q <= dc_d;
			pcomp_q <= pcomp_d;
			rate_q <= rate_d;
			lowpwr_q <= lowpwr_d;
			srst_cnt_q <= srst_cnt_d;
			rdata_q <= rdata_d;
			rdoe_q <= rdoe_d;
			wdata_q <= wdata_d;
			wstb_q <= wstb_d;
			rstb_q <= rstb_d;
			rst_q <= rst_d;
			mot_q <= mot_d;
			sel_q <= sel_dec;
			// Gated DMA and interrupt pins.
			ack_q <= ack_d;
			tc_q <= tc_d;
			drq_q <= eng_drq;
			drqoe_q <= drqoe_d;
			irq_q <= eng_irq;
			irqoe_q <= irqoe_d;
		end
	end

	// Outputs straight from flip-flops.
	assign host_rdata = rdata_q;
	assign host_rdata_oe = rdoe_q;
	assign eng_wdata = wdata_q;
	assign eng_wstb = wstb_q;
	assign eng_rstb = rstb_q;
	assign eng_reset = rst_q;
	assign eng_lowpower = lowpwr_q;
	assign eng_rate = rate_q;
	assign eng_precomp = pcomp_q;
	assign motor_out_n = mot_q;
	assign drive_sel_n = sel_q;
	assign dma_ack_n_gated = ack_q;
	assign term_count_gated = tc_q;
	assign drq_out = drq_q;
	assign drq_oe = drqoe_q;
	assign irq_out = irq_q;
	assign irq_oe = irqoe_q;
endmodule
`default_nettype wire

// [tb/fhri_eng_model.sv]
// Behavioural command engine behind the byte port.
`timescale 1ns/1ps
`default_nettype none
module fhri_eng_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic eng_wstb,
	input wire logic eng_rstb,
	input wire logic [2:0] lat,
	input wire logic [6:0] st,
	output logic [7:0] status,
	output logic [7:0] rdata,
	output logic drq,
	output logic irq
);
	logic [2:0] cnt_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 3'h0;
			rdata <= 8'h00;
		end else if (eng_wstb || eng_rstb) begin
			cnt_q <= lat;
			rdata <= rdata + {7'h0, eng_rstb};
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end
	assign status = {cnt_q == 3'h0, st};
	assign drq = cnt_q[0];
	assign irq = cnt_q == 3'h0;
endmodule
`default_nettype wire

// [tb/fhri_regs_asserts.sv]
// Checker on the host register file ports.
`timescale 1ns/1ps
`default_nettype none
module fhri_regs_asserts #(
	parameter int DRIVES = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [2:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	input wire logic host_rdata_oe,
	input wire logic eng_wstb,
	input wire logic eng_rstb,
	input wire logic eng_reset,
	input wire logic [1:0] eng_rate,
	input wire logic [1:0] motor_out_n,
	input wire logic [DRIVES-1:0] drive_sel_n,
	input wire logic drq_oe
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	// High for a write to drive control.
	logic dc_wr;
	assign dc_wr = host_wr && host_addr == 3'h2;
	rsvd_quiet_a:
	assert property (host_rd && host_addr inside {3'h0, 3'h1, 3'h3, 3'h6}
		|=> !host_rdata_oe) else $error("reserved read drove bus");
	motor_map_a:
	assert property (dc_wr |=> motor_out_n == ~$past(host_wdata[5:4]))
		else $error("motor pins wrong");
	dma_gate_a:
	assert property (dc_wr |=> drq_oe == $past(host_wdata[3]))
		else $error("request enable wrong");
	one_drive_a:
	assert property ($onehot(~drive_sel_n)) else $error("not one drive");
	run_bit_a:
	assert property (dc_wr && !host_wdata[2] |=> eng_reset)
		else $error("no reset hold");
	port_write_a:
	assert property (host_wr && host_addr == 3'h5 |=> eng_wstb)
		else $error("no write strobe");
	port_read_a:
	assert property (host_rd && host_addr == 3'h5 |=> eng_rstb && host_rdata_oe)
		else $error("no read strobe");
	soft_hold_a:
	assert property (host_wr && host_addr == 3'h4 && host_wdata[7]
		|=> eng_reset [*8]) else $error("soft reset short");
	alt_rate_a:
	assert property (host_wr && host_addr == 3'h7
		|=> eng_rate == $past(host_wdata[1:0])) else $error("rate wrong");
	cover property (dc_wr && host_wdata == 8'h8f);
	cover property (eng_rstb);
	cover property (eng_reset && motor_out_n != 2'b11);
endmodule
bind fhri_regs fhri_regs_asserts #(.DRIVES(DRIVES)) u_chk (.core_clk,
	.nrst, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata_oe,
	.eng_wstb, .eng_rstb, .eng_reset, .eng_rate, .motor_out_n,
	.drive_sel_n, .drq_oe);
`default_nettype wire

// [tb/fhri_regs_tb.sv]
// Self-checking bench for the host register file.
`timescale 1ns/1ps
`default_nettype none
module fhri_regs_tb;
	logic core_clk = 0, nrst = 0, host_rd = 0, host_wr = 0;
	logic [2:0] host_addr = 0, lat = 0, eng_precomp;
	logic [7:0] host_wdata = 0, host_rdata, eng_wdata, eng_rdata, es, d, v;
	logic [6:0] st = 0;
	logic media_change_in_n = 1, dma_ack_n = 1, term_count = 0;
	logic host_rdata_oe, eng_wstb, eng_rstb, eng_reset, eng_lowpower;
	logic [1:0] eng_rate, motor_out_n;
	logic [3:0] drive_sel_n;
	logic dma_ack_n_gated, term_count_gated, drq_out, drq_oe, irq_out;
	logic irq_oe, eng_drq, eng_irq;
	int n_fail = 0, num_checks = 0, nrd = 0, i, seed = 32'h4acead8b;
	logic [7:0] tbl [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
	logic [1:0] pin_q;
	always #2.5 core_clk = ~core_clk;
	// Engine request and interrupt as the design sampled them.
	always @(posedge core_clk) pin_q <= {eng_drq, eng_irq};
	fhri_eng_model eng (.core_clk, .nrst, .eng_wstb, .eng_rstb, .lat, .st,
		.status(es), .rdata(eng_rdata), .drq(eng_drq), .irq(eng_irq));
	fhri_regs dut (.core_clk, .nrst, .host_addr, .host_rd, .host_wr,
		.host_wdata, .host_rdata, .host_rdata_oe, .eng_rqm(es[7]),
		.eng_dio(es[6]), .eng_nondma(es[5]), .eng_cmd_busy(es[4]),
		.eng_seek_busy(es[3:0]), .eng_wdata, .eng_wstb, .eng_rdata,
		.eng_rstb, .eng_reset, .eng_lowpower, .eng_rate, .eng_precomp,
		.motor_out_n, .drive_sel_n, .media_change_in_n, .dma_ack_n,
		.term_count, .eng_drq, .eng_irq, .dma_ack_n_gated, .term_count_gated,
		.drq_out, .drq_oe, .irq_out, .irq_oe);
	task automatic conclude();
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// One host access, driven between falling edges.
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] x);
		@(negedge core_clk);
		host_addr = a;
		host_wr = w;
		host_rd = !w;
		host_wdata = x;
		@(negedge core_clk);
		host_wr = 0;
		host_rd = 0;
	endtask
	task automatic chk_dc(input logic [7:0] x);
		chk({motor_out_n, drive_sel_n, eng_reset, drq_oe},
			{~x[5:4], ~(4'h1 << x[1:0]), ~x[2], x[3]});
	endtask
	task automatic chk_rs(input logic [7:0] x);
		chk({eng_reset, eng_lowpower, 1'b0, eng_precomp, eng_rate}, x);
	endtask
	// Polls status until the port is ready.
	task automatic ready();
		d = 0;
		for (int k = 0; k < 20 && !d[7]; k++) begin
			acc(0, 3'h4, 8'h00);
			d = host_rdata;
			chk({6'h0, drq_out, irq_out}, {6'h0, pin_q});
		end
		chk(d, {1'b1, st});
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		nrst = 1;
		chk({motor_out_n, eng_precomp, eng_rate, eng_reset}, 8'hc5);
		chk({4'h0, drive_sel_n}, 8'h0e);
		for (i = 0; i < 8; i++) begin
			v = i < 4 ? tbl[i] : 8'($random(seed));
			dma_ack_n = v[6];
			term_count = v[7];
			acc(1, 3'h2, v);
			chk_dc(v);
			@(negedge core_clk);
			chk({irq_oe, dma_ack_n_gated, term_count_gated},
				{v[3], v[3] ? v[6] : 1'b1, v[3] & v[7]});
			// Software keeps the run bit low for the least reset time.
			if (!v[2]) repeat (fhri_pkg::RST_MIN_CYC) @(negedge core_clk);
		end
		acc(1, 3'h2, 8'h1c);
		acc(0, 3'h2, 8'h00);
		chk(host_rdata, 8'h1c);
		for (i = 0; i < 8; i++) begin
			if (!(i inside {2, 4, 5, 7})) begin
				acc(1, i[2:0], 8'hff);
				acc(0, i[2:0], 8'h00);
				chk({7'h0, host_rdata_oe}, 8'h00);
			end
		end
		chk_dc(8'h1c);
		v = 8'($random(seed)) & 8'h1f;
		acc(1, 3'h4, v | 8'h80);
		chk_rs(v | 8'h80);
		chk_dc(8'h18);
		repeat (fhri_pkg::RST_MIN_CYC - 1) @(negedge core_clk);
		chk({7'h0, eng_reset}, 8'h01);
		@(negedge core_clk);
		chk_dc(8'h1c);
		v = 8'($random(seed));
		acc(1, 3'h7, v);
		chk({6'h0, eng_rate}, {6'h0, v[1:0]});
		acc(1, 3'h4, 8'h4b);
		chk_rs(8'h4b);
		acc(0, 3'h4, 8'h00);
		chk({7'h0, eng_lowpower}, 8'h00);
		for (i = 0; i < 2; i++) begin
			media_change_in_n = i[0];
			acc(0, 3'h7, 8'h00);
			chk({host_rdata[7], host_rdata_oe}, {~i[0], 1'b1});
		end
		for (i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			lat = v[2:0];
			st = 7'($random(seed));
			ready();
			if (i[0]) begin
				acc(0, 3'h5, 8'h00);
				chk(host_rdata, 8'(nrd));
				nrd++;
				chk({eng_rstb, host_rdata_oe}, 8'h03);
			end else begin
				acc(1, 3'h5, v);
				chk(eng_wdata, v);
				chk({7'h0, eng_wstb}, 8'h01);
			end
		end
		conclude();
	end
	initial begin
		#20000;
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
